// File: verilog/llp_map.vh
`ifndef LLP_MAP_VH
`define LLP_MAP_VH

// Register word offsets (Avalon word addressing)
`define LLP_OFS_STATUS     2'h0
`define LLP_OFS_TIMER_MS   2'h1
`define LLP_OFS_CURRENT    2'h2
`define LLP_OFS_CTRL       2'h3

// Status field positions
`define LLP_ST_CODE_LSB    0
`define LLP_ST_CODE_MSB    4
`define LLP_ST_MODE_LSB    8
`define LLP_ST_MODE_MSB    9
`define LLP_ST_PUMP_LSB    12
`define LLP_ST_PUMP_MSB    13
`define LLP_ST_SHUTDOWN    16
`define LLP_ST_TIMER_EN    17
`define LLP_ST_EXPIRED     18
`define LLP_ST_ON          19

// Control field positions
`define LLP_CTRL_TIMER_ALLOW 0

// Reset values
`define LLP_RST_TIMER_MS   16'h03e8
`define LLP_RST_CTRL       1'h1

// Output mode codes
`define LLP_MODE_OFF       2'h0
`define LLP_MODE_FLASH     2'h1
`define LLP_MODE_TORCH     2'h2

// Pump conversion mode codes
`define LLP_PUMP_1X        2'h0
`define LLP_PUMP_1P5X      2'h1
`define LLP_PUMP_2X        2'h2

// Level codes
`define LLP_CODE_MAX       5'h10
`define LLP_CODE_LAST_HIGH 5'h04

// Timing: times in their own units, clock rate in MHz
`define LLP_CLK_MHZ        20
`define LLP_T_OFF_US       500
`define LLP_LATCH_TIMEOUT_US       500
`define LLP_T_MS_US        1000

`endif

// File: verilog/llp_level_rom.v
`timescale 1ns/100ps
`include "llp_map.vh"

module llp_level_rom
(
  input  wire        clk_sys_in,   // System clock
  input  wire        rst_b_in,     // Async reset, active low
  input  wire [4:0]  code_in,      // Level code 0..16
  output reg  [13:0] pct_out       // Current in hundredths of percent
);

  // Percent of maximum, registered lookup
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pct_out <= 14'h0000;
    else
    begin
      case (code_in)
        5'h01:   pct_out <= 14'd10001;
        5'h02:   pct_out <= 14'd8911;
        5'h03:   pct_out <= 14'd7941;
        5'h04:   pct_out <= 14'd7081;
        5'h05:   pct_out <= 14'd6310;
        5'h06:   pct_out <= 14'd5620;
        5'h07:   pct_out <= 14'd5010;
        5'h08:   pct_out <= 14'd4470;
        5'h09:   pct_out <= 14'd3980;
        5'h0a:   pct_out <= 14'd3550;
        5'h0b:   pct_out <= 14'd3160;
        5'h0c:   pct_out <= 14'd2820;
        5'h0d:   pct_out <= 14'd2510;
        5'h0e:   pct_out <= 14'd2240;
        5'h0f:   pct_out <= 14'd2000;
        default: pct_out <= 14'h0000;
      endcase
    end
  end

endmodule

// File: verilog/llp_programmer.v
`timescale 1ns/100ps
`include "llp_map.vh"

module llp_programmer
#(
  parameter OFF_CYC = `LLP_T_OFF_US * `LLP_CLK_MHZ,  // Off timeout in cycles
  parameter LAT_CYC = `LLP_LATCH_TIMEOUT_US * `LLP_CLK_MHZ,  // Latch timeout in cycles
  parameter MS_CYC  = `LLP_T_MS_US * `LLP_CLK_MHZ    // Cycles per timer tick
)
(
  input  wire        clk_sys_in,             // System clock, 20 MHz
  input  wire        rst_b_in,               // Async reset, active low
  input  wire [1:0]  avs_address,            // Avalon word address
  input  wire        avs_read,               // Avalon read request
  input  wire        avs_write,              // Avalon write request
  input  wire [31:0] avs_writedata,          // Avalon write data
  output reg  [31:0] avs_readdata,           // Avalon read data
  output wire        avs_waitrequest,        // Avalon wait request
  input  wire        en_level_in,            // Enable/level line pin
  input  wire        flash_enable_input_in,  // Flash-enable pin level
  input  wire        timer_capacitor_pin_in, // Timing pin level, 1 = released
  input  wire        pump_headroom_ok_in,    // Pump output sustains LED current
  output reg  [4:0]  level_code_out,         // Active level code, 0 = none
  output wire [13:0] current_pct_out,        // Current, hundredths of percent
  output reg         led_on_out,             // Current source enabled
  output reg  [1:0]  out_mode_out,           // Off, flash or torch
  output reg  [1:0]  pump_mode_out,          // 1X, 1.5X or 2X
  output reg         timer_enabled_out,      // Auto-timer armed
  output reg         shutdown_out            // Device in shutdown
);

  // Two-stage synchronisers for pins
  reg  [1:0]  en_sync_r;
  reg  [1:0]  fle_sync_r;
  reg  [1:0]  tcp_sync_r;
  reg  [1:0]  hdr_sync_r;
  reg         en_prev_r;

  // Programming state
  reg  [4:0]  data_r;        // Counted rising edges
  reg  [4:0]  addr_r;        // Applied level code
  reg  [13:0] off_cnt_r;
  reg  [13:0] lat_cnt_r;
  reg         shut_r;

  // Auto-timer state
  reg  [14:0] ms_cnt_r;
  reg  [15:0] tmr_cnt_r;
  reg         tmr_run_r;
  reg         expired_r;

  // Software registers
  reg  [15:0] timer_ms_r;
  reg         ctrl_allow_r;
  reg         ack_r;

  // Decode and handshake nets
  wire        en_s;
  wire        en_rise;
  wire        fle_s;
  wire        tcp_s;
  wire        hdr_s;
  wire        off_hit;
  wire        lat_hit;
  wire        tmr_armed;
  wire [4:0]  addr_nxt;
  wire        new_high;
  wire        tmr_done;
  wire        ms_tick;
  wire        bus_req;
  wire [31:0] status_w;
  wire [13:0] pct_w;

  // High-current code test, used for old and new levels
  function is_high;
    input [4:0] code;
    begin
      is_high = (code != 5'h00) && (code <= `LLP_CODE_LAST_HIGH);
    end
  endfunction

  // Pin synchronisers
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      en_sync_r  <= 2'h0;
      fle_sync_r <= 2'h0;
      tcp_sync_r <= 2'h0;
      hdr_sync_r <= 2'h0;
      en_prev_r  <= 1'h0;
    end
    else
    begin
      en_sync_r  <= {en_sync_r[0], en_level_in};
      fle_sync_r <= {fle_sync_r[0], flash_enable_input_in};
      tcp_sync_r <= {tcp_sync_r[0], timer_capacitor_pin_in};
      hdr_sync_r <= {hdr_sync_r[0], pump_headroom_ok_in};
      en_prev_r  <= en_sync_r[1];
    end
  end

  // Synchronised levels and line rising edge
  assign en_s    = en_sync_r[1];
  assign fle_s   = fle_sync_r[1];
  assign tcp_s   = tcp_sync_r[1];
  assign hdr_s   = hdr_sync_r[1];
  assign en_rise = en_s & ~en_prev_r;

  // Timeout detection
  // Low and high runs are exclusive, so off and latch never coincide
  assign off_hit = ~en_s && (off_cnt_r == OFF_CYC[13:0] - 14'h0001);
  assign lat_hit = en_s && (data_r != 5'h00) && (lat_cnt_r == LAT_CYC[13:0] - 14'h0001);
  assign addr_nxt = lat_hit ? data_r : addr_r;
  assign new_high = lat_hit && is_high(data_r) && !is_high(addr_r);

  // Low and high time counters
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      off_cnt_r <= 14'h0000;
      lat_cnt_r <= 14'h0000;
    end
    else
    begin
      if (en_s || off_hit)
        off_cnt_r <= 14'h0000;
      else
        off_cnt_r <= off_cnt_r + 14'h0001;
      if (!en_s || en_rise || lat_hit)
        lat_cnt_r <= 14'h0000;
      else if (data_r != 5'h00)
        lat_cnt_r <= lat_cnt_r + 14'h0001;
    end
  end

  // Edge counting, latching and shutdown
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      data_r <= 5'h00;
      addr_r <= 5'h00;
      shut_r <= 1'h1;
    end
    else if (off_hit)
    begin
      data_r <= 5'h00;
      addr_r <= 5'h00;
      shut_r <= 1'h1;
    end
    else
    begin
      if (en_rise)
      begin
        shut_r <= 1'h0;
        if (data_r != `LLP_CODE_MAX)
          data_r <= data_r + 5'h01;
      end
      else if (lat_hit)
      begin
        addr_r <= data_r;
        data_r <= 5'h00;
      end
    end
  end

  // Timer may run only for high codes with the pin released
  assign tmr_armed = is_high(addr_r) && tcp_s && ctrl_allow_r;
  assign ms_tick   = (ms_cnt_r == MS_CYC[14:0] - 15'h0001);
  assign tmr_done  = tmr_run_r && ms_tick && (tmr_cnt_r + 16'h0001 >= timer_ms_r);

  // Flash auto-timer
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ms_cnt_r  <= 15'h0000;
      tmr_cnt_r <= 16'h0000;
      tmr_run_r <= 1'h0;
      expired_r <= 1'h0;
    end
    else if (off_hit)
    begin
      ms_cnt_r  <= 15'h0000;
      tmr_cnt_r <= 16'h0000;
      tmr_run_r <= 1'h0;
      expired_r <= 1'h0;
    end
    else if (lat_hit)
    begin
      ms_cnt_r  <= 15'h0000;
      tmr_cnt_r <= 16'h0000;
      expired_r <= 1'h0;
      if (new_high)
        tmr_run_r <= 1'h1;
      else if (!is_high(data_r))
        tmr_run_r <= 1'h0;
      else
        tmr_run_r <= tmr_run_r | (addr_r == 5'h00);
    end
    else if (!tmr_armed)
    begin
      ms_cnt_r  <= 15'h0000;
      tmr_cnt_r <= 16'h0000;
    end
    else if (tmr_run_r && !expired_r)
    begin
      if (tmr_done)
      begin
        expired_r <= 1'h1;
        tmr_run_r <= 1'h0;
      end
      else if (ms_tick)
      begin
        ms_cnt_r  <= 15'h0000;
        tmr_cnt_r <= tmr_cnt_r + 16'h0001;
      end
      else
        ms_cnt_r <= ms_cnt_r + 15'h0001;
    end
  end

  // Charge pump mode: restart at 1X, step up while short of headroom
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pump_mode_out <= `LLP_PUMP_1X;
    else if (off_hit || lat_hit || !led_on_out)
      pump_mode_out <= `LLP_PUMP_1X;
    else if (!hdr_s)
    begin
      case (pump_mode_out)
        `LLP_PUMP_1X:   pump_mode_out <= `LLP_PUMP_1P5X;
        `LLP_PUMP_1P5X: pump_mode_out <= `LLP_PUMP_2X;
        `LLP_PUMP_2X:   pump_mode_out <= `LLP_PUMP_2X;
        default:        pump_mode_out <= `LLP_PUMP_1X;
      endcase
    end
  end

  // Output mode, level and enable
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      out_mode_out      <= `LLP_MODE_OFF;
      level_code_out    <= 5'h00;
      led_on_out        <= 1'h0;
      timer_enabled_out <= 1'h0;
      shutdown_out      <= 1'h1;
    end
    else
    begin
      if (!en_s)
        out_mode_out <= `LLP_MODE_OFF;
      else if (fle_s)
        out_mode_out <= `LLP_MODE_TORCH;
      else
        out_mode_out <= `LLP_MODE_FLASH;
      level_code_out    <= addr_nxt;
      led_on_out        <= en_s && !shut_r && (addr_r != 5'h00) && (addr_r != `LLP_CODE_MAX) && !expired_r;
      timer_enabled_out <= tmr_armed;
      shutdown_out      <= shut_r;
    end
  end

  // Current percentage lookup
  llp_level_rom llp_level_rom_inst
  (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .code_in    (addr_r),
    .pct_out    (pct_w)
  );

  // Table value drives the pin directly
  assign current_pct_out = pct_w;

  // Status word
  assign status_w = {12'h000, led_on_out, expired_r, timer_enabled_out, shutdown_out,
                     2'h0, pump_mode_out, 2'h0, out_mode_out, 3'h0, level_code_out};

  // Avalon slave: one wait cycle per access
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;

  // Read captured in cycle 0, write committed on the acknowledged edge
  always @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack_r        <= 1'h0;
      avs_readdata <= 32'h00000000;
      timer_ms_r   <= `LLP_RST_TIMER_MS;
      ctrl_allow_r <= `LLP_RST_CTRL;
    end
    else
    begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read && !ack_r)
      begin
        case (avs_address)
          `LLP_OFS_STATUS:   avs_readdata <= status_w;
          `LLP_OFS_TIMER_MS: avs_readdata <= {16'h0000, timer_ms_r};
          `LLP_OFS_CURRENT:  avs_readdata <= {18'h00000, pct_w};
          `LLP_OFS_CTRL:     avs_readdata <= {31'h00000000, ctrl_allow_r};
          default:           avs_readdata <= 32'h00000000;
        endcase
      end
      if (avs_write && ack_r)
      begin
        case (avs_address)
          `LLP_OFS_TIMER_MS: timer_ms_r   <= avs_writedata[15:0];
          `LLP_OFS_CTRL:     ctrl_allow_r <= avs_writedata[`LLP_CTRL_TIMER_ALLOW];
          default:           ctrl_allow_r <= ctrl_allow_r;
        endcase
      end
    end
  end

endmodule

// File: test/llp_programmer_monitor.sv
`timescale 1ns/100ps
module llp_chk
#(
  parameter OFF_CYC = 40,
  parameter LAT_CYC = 40
)
(
  input logic        clk_sys_in,             // Clock
  input logic        rst_b_in,               // Reset
  input logic        en_level_in,            // Level line
  input logic        flash_enable_input_in,  // Flash select
  input logic        timer_capacitor_pin_in, // Timing pin
  input logic [4:0]  level_code_out,         // Code
  input logic [13:0] current_pct_out,        // Current
  input logic        led_on_out,             // Led on
  input logic [1:0]  out_mode_out,           // Mode
  input logic [1:0]  pump_mode_out,          // Pump
  input logic        timer_enabled_out,      // Timer armed
  input logic        shutdown_out            // Shutdown
);
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;

  // Run lengths of the raw level line
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      hi_cnt_r <= 16'h0000;
      lo_cnt_r <= 16'h0000;
    end
    else
    begin
      hi_cnt_r <= en_level_in ? hi_cnt_r + 16'h0001 : 16'h0000;
      lo_cnt_r <= en_level_in ? 16'h0000 : lo_cnt_r + 16'h0001;
    end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  a_off_mode: assert property (!en_level_in [*5] |-> out_mode_out == 2'h0)
    else $error("mode not off with line low");
  a_flash_pick: assert property ((en_level_in && !flash_enable_input_in) [*5] |-> out_mode_out != 2'h2)
    else $error("torch with flash selected");
  a_timer_gate: assert property (timer_enabled_out && $stable(level_code_out)
    |-> level_code_out inside {[5'h01:5'h04]})
    else $error("timer armed for low current code");
  a_pin_disables: assert property (!timer_capacitor_pin_in [*5] |-> !timer_enabled_out)
    else $error("timer armed with pin held low");
  a_shutdown_clears: assert property (shutdown_out |-> level_code_out == 5'h00 && !led_on_out)
    else $error("level kept in shutdown");
  a_off_timeout: assert property (lo_cnt_r >= OFF_CYC + 5 |-> shutdown_out)
    else $error("no shutdown after long low");
  a_early_off: assert property ($rose(shutdown_out) |-> lo_cnt_r >= OFF_CYC)
    else $error("shutdown too early");
  a_latch_wait: assert property ($changed(level_code_out) && level_code_out != 5'h00
    |-> hi_cnt_r >= LAT_CYC)
    else $error("level applied before latch time");
  a_code_sat: assert property (level_code_out <= 5'h10)
    else $error("code above sixteen");
  a_pump_reset: assert property ($changed(level_code_out) |-> pump_mode_out == 2'h0)
    else $error("pump not reset on new level");
  a_pump_step: assert property ($changed(pump_mode_out) && pump_mode_out != 2'h0
    |-> pump_mode_out == $past(pump_mode_out) + 2'h1)
    else $error("pump skipped a mode");
  a_pct_ends: assert property ($stable(level_code_out)
    |-> (level_code_out != 5'h01 || current_pct_out == 14'h2711)
    && (level_code_out != 5'h10 || current_pct_out == 14'h0000))
    else $error("current table end wrong");
endmodule

// Checker defaults equal the bench's 40-cycle timeouts
bind llp_programmer llp_chk llp_chk_inst
(
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .en_level_in(en_level_in),
  .flash_enable_input_in(flash_enable_input_in), .timer_capacitor_pin_in(timer_capacitor_pin_in),
  .level_code_out(level_code_out), .current_pct_out(current_pct_out), .led_on_out(led_on_out),
  .out_mode_out(out_mode_out), .pump_mode_out(pump_mode_out), .timer_enabled_out(timer_enabled_out),
  .shutdown_out(shutdown_out)
);

// File: test/llp_host_model.sv
`timescale 1ns/100ps
module llp_host
#(
  parameter OFF_CYC = 40,
  parameter LAT_CYC = 40
)
(
  input  logic clk_sys_in, // Clock
  output logic en_out,     // Level line
  output logic fl_oe_out,  // Flash select pulled low
  output logic ct_oe_out   // Timing pin pulled low
);
  // Line low, open-drain outputs released
  initial
  begin
    en_out    = 1'b0;
    fl_oe_out = 1'b0;
    ct_oe_out = 1'b0;
  end

  // n rising edges, two cycles low and three high, then hold to latch
  task program_level(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_in) en_out <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      en_out <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
    end
    repeat (LAT_CYC + 6) @(posedge clk_sys_in);
  endtask

  // Hold the line low past the off timeout
  task go_off;
    @(posedge clk_sys_in) en_out <= 1'b0;
    repeat (OFF_CYC + 6) @(posedge clk_sys_in);
  endtask

  // Pins only ever pulled low or released
  task pins(input logic fl_low, input logic ct_low);
    @(posedge clk_sys_in);
    fl_oe_out <= fl_low;
    ct_oe_out <= ct_low;
  endtask
endmodule

// File: test/tb_llp_programmer.sv
`timescale 1ns/100ps
module tb_llp_programmer;
  localparam int OFF = 40;
  localparam int LAT = 40;
  logic        clk_sys_in    = 1'b0;
  logic        rst_b_in      = 1'b0;
  logic [1:0]  avs_address   = 2'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic        hr            = 1'b1;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, en, fl_oe, ct_oe, led, tmr_en, sd;
  logic [4:0]  code;
  logic [13:0] pct;
  logic [1:0]  mode, pump;
  int          n_errors        = 0;
  int          samples_checked = 0;
  logic [13:0] pct_tbl [1:16]  = '{14'h2711, 14'h22cf, 14'h1f05, 14'h1ba9, 14'h18a6, 14'h15f4, 14'h1392,
    14'h1176, 14'h0f8c, 14'h0dde, 14'h0c58, 14'h0b04, 14'h09ce, 14'h08c0, 14'h07d0, 14'h0000};

  always #25 clk_sys_in = ~clk_sys_in;

  // Host model keeps its own 40-cycle timeouts, equal to OFF and LAT
  llp_host llp_host_inst
  (
    .clk_sys_in(clk_sys_in), .en_out(en), .fl_oe_out(fl_oe), .ct_oe_out(ct_oe)
  );

  llp_programmer #(.OFF_CYC(OFF), .LAT_CYC(LAT), .MS_CYC(8)) llp_programmer_inst
  (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .en_level_in(en), .flash_enable_input_in(~fl_oe),
    .timer_capacitor_pin_in(~ct_oe), .pump_headroom_ok_in(hr), .level_code_out(code),
    .current_pct_out(pct), .led_on_out(led), .out_mode_out(mode), .pump_mode_out(pump),
    .timer_enabled_out(tmr_en), .shutdown_out(sd)
  );

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task bus(input logic wr, input logic [1:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk_sys_in);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= wd;
    k = 0;
    @(posedge clk_sys_in);
    while (avs_waitrequest !== 1'b0 && k < 20)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k == 20)
      n_errors++;
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rdchk(input logic [1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    final_report;
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rdchk(2'h0, 32'h0001_0000);
    rdchk(2'h1, 32'h0000_03e8);
    rdchk(2'h3, 32'h0000_0001);
    bus(1'b1, 2'h0, 32'hffff_ffff);
    rdchk(2'h0, 32'h0001_0000);
    bus(1'b1, 2'h1, 32'h0000_0003);
    for (int c = 1; c <= 16; c++)
    begin
      llp_host_inst.program_level(c);
      check(code, c[4:0]);
      check(pct, pct_tbl[c]);
      check(tmr_en, c <= 4);
    end
    check(led, 1'b0);
    llp_host_inst.program_level(20);
    check(code, 5'h10);
    llp_host_inst.program_level(2);
    check(led, 1'b1);
    check(mode, 2'h2);
    llp_host_inst.pins(1'b1, 1'b0);
    repeat (5) @(posedge clk_sys_in);
    check(mode, 2'h1);
    repeat (40) @(posedge clk_sys_in);
    check(led, 1'b0);
    rdchk(2'h0, 32'h0006_0102);
    llp_host_inst.program_level(6);
    repeat (60) @(posedge clk_sys_in);
    check(led, 1'b1);
    llp_host_inst.program_level(3);
    check(led, 1'b1);
    repeat (50) @(posedge clk_sys_in);
    check(led, 1'b0);
    llp_host_inst.pins(1'b1, 1'b1);
    llp_host_inst.program_level(1);
    repeat (60) @(posedge clk_sys_in);
    check({led, tmr_en}, 2'b10);
    llp_host_inst.pins(1'b1, 1'b0);
    bus(1'b1, 2'h3, 32'h0);
    llp_host_inst.program_level(4);
    check(tmr_en, 1'b0);
    hr <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    check(pump, 2'h2);
    hr <= 1'b1;
    llp_host_inst.program_level(5);
    check(pump, 2'h0);
    bus(1'b1, 2'h3, 32'h1);
    llp_host_inst.go_off();
    check({sd, code, mode}, 8'h80);
    rdchk(2'h0, 32'h0001_0000);
    final_report;
  end
endmodule
